// [shared/amxs_pkg.sv]
// Purpose: Shared constants and types for the analog input mux sequencer.
// Assumes: One 250 MHz system clock; the 32768 Hz clock arrives as a synchronous level.
// Notes: Select codes equal the data RAM word that receives the result.

package amxs_pkg;

  // ---------------------------------------------------------------------------
  // Slot list and widths
  // ---------------------------------------------------------------------------
  localparam int SLOT_COUNT = 10;
  localparam int SEL_W = 4;
  localparam int SEL_BUS_W = SLOT_COUNT * SEL_W;
  localparam int FILT_W = 24;
  localparam int WORD_W = 32;
  localparam int ADDR_W = 10;
  localparam int FIFO_W = ADDR_W + WORD_W;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FRAME_LEN_MAX = 4'hA;
  localparam logic [3:0] FRAME_LEN_MIN = 4'h1;
  localparam int RESULT_SHIFT = 8;

  // ---------------------------------------------------------------------------
  // Data RAM words for each input
  // ---------------------------------------------------------------------------
  localparam logic [SEL_W-1:0] ADDR_PHASE_A_CURRENT = 4'h0;
  localparam logic [SEL_W-1:0] ADDR_PHASE_B_VOLTAGE = 4'h1;
  localparam logic [SEL_W-1:0] ADDR_PHASE_B_CURRENT = 4'h2;
  localparam logic [SEL_W-1:0] ADDR_PHASE_A_VOLTAGE = 4'h3;
  localparam logic [SEL_W-1:0] ADDR_AUXILIARY = 4'h9;
  localparam logic [SEL_W-1:0] ADDR_TEMPERATURE = 4'hA;
  localparam logic [SEL_W-1:0] ADDR_BATTERY = 4'hB;

  // ---------------------------------------------------------------------------
  // Chopper modes and clock-speed setting
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CHOP_TOGGLE_FORCED = 2'h0;
  localparam logic [1:0] CHOP_FIXED_LOW = 2'h1;
  localparam logic [1:0] CHOP_FIXED_HIGH = 2'h2;
  localparam logic [1:0] CHOP_TOGGLE_FREE = 2'h3;
  localparam logic [1:0] CLK_SEL_HI_RES = 2'h1;

  // ---------------------------------------------------------------------------
  // Conversion duration in 32768 Hz cycles, and result resolution in bits
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CONV_CYCLES_LEN0 = 2'h1;
  localparam logic [1:0] CONV_CYCLES_LEN1 = 2'h2;
  localparam logic [1:0] CONV_CYCLES_LEN2 = 2'h3;
  localparam logic [4:0] RES_STD_LEN0 = 5'h12;
  localparam logic [4:0] RES_STD_LEN1 = 5'h15;
  localparam logic [4:0] RES_STD_LEN2 = 5'h16;
  localparam logic [4:0] RES_HI_LEN0 = 5'h13;
  localparam logic [4:0] RES_HI_LEN1 = 5'h16;
  localparam logic [4:0] RES_HI_LEN2 = 5'h18;

  // ---------------------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_WAIT_EDGE,
    ST_CONVERT,
    ST_PUSH,
    ST_HOLD,
    ST_SYNC
  } amxs_state_type;

endpackage

// [rtl/amxs_fifo.sv]
// Purpose: Result FIFO between the sequencer and the data RAM write port.
// Assumes: One clock, synchronous active-high reset.
// Notes: Full and empty are exact; a write while full is refused by in_ready low.

`timescale 1ns/100ps

module amxs_fifo #(
  parameter int WIDTH = amxs_pkg::FIFO_W,
  parameter int DEPTH = amxs_pkg::FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  import amxs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } amxs_fifo_state_type;

  amxs_fifo_state_type s_r;
  amxs_fifo_state_type s_nxt;
  logic full;
  logic empty;

  assign empty = (s_r.wp == s_r.rp);
  assign full = (s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = s_r.mem[s_r.rp[AW-1:0]];

  always_comb begin
    s_nxt = s_r;
    if (i_in_valid && !full) begin
      s_nxt.mem[s_r.wp[AW-1:0]] = i_in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (i_out_ready && !empty) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// [rtl/amxs_sequencer.sv]
// Purpose: Analog input mux sequencer: slot lists, conversion pacing, chopper and frame sync.
// Assumes: I_SLOW_32K_CLOCK is a level synchronous to I_SYS_CLK; results leave via a FIFO.
// Notes: Functional notes below.
// Functional notes
// R01 - Slot input comes from normal list, or alternate list in alternate frames.
// R02 - Battery source is loaded only while battery measure enable is set.
// R03 - Request edge yields exactly one alternate frame at the next frame boundary.
// R04 - A request held for a single cycle is still caught.
// R05 - Frame length field gives 1 to 10 slots per frame.
// R06 - Each frame starts at slot 0 and proceeds in list order.
// R07 - Slots begin on slow clock rising edge with a conversion start command.
// R08 - After conversion complete, wait for next slow clock rising edge to advance.
// R09 - Filter length 0, 1, 2 means 1, 2, 3 slow clock cycles.
// R10 - Resolution follows clock-speed bits and filter length.
// R11 - Each result goes to the fixed RAM word of its input.
// R12 - Results stored right-aligned, then shifted left by eight bits.
// R13 - One extra slow cycle after last slot; polarity updates at its start.
// R14 - Frame sync high during extra cycle; its rise starts an engine pass.
// R15 - Mode 01 holds polarity and chopper clock low; 10 holds both high.
// R16 - Mode 00 toggles every frame except the one before the forced alternate frame, and forces alternate last frame per interval.
// R17 - Mode 00 skips the toggle just before the forced alternate frame.
// R18 - Mode 11 forces no alternate frame and toggles every frame.
// R19 - High polarity reverses the reference amplifier input connection.
// R20 - Software never replaces phase A voltage in alternate slot selections.
// R21 - Frames per accumulation interval are always even.
// R22 - Sequencer runs on the slow clock and launches each engine pass.
// R23 - Interval is first-stage frames repeated second-stage count times.
// R24 - A request during a running alternate frame is served at the next boundary.

`timescale 1ns/100ps

module amxs_sequencer (
  input wire logic I_SYS_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_SLOW_32K_CLOCK,
  input wire logic [amxs_pkg::SEL_BUS_W-1:0] I_NORMAL_SLOT_SELECT,
  input wire logic [amxs_pkg::SEL_BUS_W-1:0] I_ALTERNATE_SLOT_SELECT,
  input wire logic [3:0] I_FRAME_LENGTH,
  input wire logic [1:0] I_FILTER_LENGTH_FIELD,
  input wire logic I_FAST_CLOCK_SEL_HI,
  input wire logic I_FAST_CLOCK_SEL_LO,
  input wire logic [1:0] I_CHOPPER_MODE_FIELD,
  input wire logic I_ALTERNATE_FRAME_REQUEST,
  input wire logic I_BATTERY_MEASURE_ENABLE,
  input wire logic [1:0] I_FIRST_STAGE_COUNT,
  input wire logic [5:0] I_SECOND_STAGE_COUNT,
  input wire logic I_CONVERSION_COMPLETE,
  input wire logic [amxs_pkg::FILT_W-1:0] I_FILTER_DATA,
  input wire logic I_RAM_WR_READY,
  output logic O_CONVERSION_START_CMD,
  output logic [amxs_pkg::SEL_W-1:0] O_INPUT_SELECT,
  output logic [1:0] O_CONV_SLOW_32K_CLOCK_CYCLES,
  output logic [4:0] O_RESOLUTION_BITS,
  output logic O_BATTERY_LOAD_EN,
  output logic O_CHOPPER_POLARITY,
  output logic O_CHOPPER_CLOCK,
  output logic O_FRAME_SYNC,
  output logic O_ALT_FRAME_ACTIVE,
  output logic O_RAM_WR_VALID,
  output logic [amxs_pkg::ADDR_W-1:0] O_RAM_WR_ADDR,
  output logic [amxs_pkg::WORD_W-1:0] O_RAM_WR_DATA
);
  import amxs_pkg::*;

  typedef struct packed {
    amxs_state_type state;
    logic ck_d;
    logic req_d;
    logic pend;
    logic alt;
    logic [3:0] slot;
    logic [SEL_W-1:0] sel;
    logic start;
    logic frame_sync;
    logic pol;
    logic chopper_clock;
    logic batt;
    logic [2:0] s1;
    logic [5:0] s2;
    logic [1:0] cycles;
    logic [4:0] res;
    logic [FIFO_W-1:0] push_word;
    logic out_valid;
    logic [FIFO_W-1:0] out_word;
  } amxs_seq_state_type;

  amxs_seq_state_type s;
  amxs_seq_state_type n;

  // ---------------------------------------------------------------------------
  // Slot select fields
  // ---------------------------------------------------------------------------
  logic [SEL_W-1:0] norm_sel [SLOT_COUNT];
  logic [SEL_W-1:0] alt_sel [SLOT_COUNT];

  generate
    for (genvar i = 0; i < SLOT_COUNT; i++) begin : g_slot
      assign norm_sel[i] = I_NORMAL_SLOT_SELECT[i*SEL_W +: SEL_W];
      assign alt_sel[i] = I_ALTERNATE_SLOT_SELECT[i*SEL_W +: SEL_W];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Derived conditions
  // ---------------------------------------------------------------------------
  logic ck_rise;
  logic req_rise;
  logic [3:0] frame_len;
  logic last_slot;
  logic [2:0] s1_max;
  logic [5:0] s2_max;
  logic last_of_interval;
  logic penult_of_interval;
  logic forced_alt;
  logic toggle_mode;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [FIFO_W-1:0] fifo_out_data;
  logic fifo_pop;
  logic [24:0] res_mask;
  logic do_start;
  logic new_frame;
  logic [3:0] start_slot;
  logic start_alt;
  logic [3:0] safe_slot;

  assign ck_rise = I_SLOW_32K_CLOCK && !s.ck_d; // see R22
  assign req_rise = I_ALTERNATE_FRAME_REQUEST && !s.req_d; // see R04
  // Out-of-range lengths are clamped so the frame always ends.
  assign frame_len = (I_FRAME_LENGTH < FRAME_LEN_MIN) ? FRAME_LEN_MIN :
                     (I_FRAME_LENGTH > FRAME_LEN_MAX) ? FRAME_LEN_MAX : I_FRAME_LENGTH; // see R05
  assign last_slot = (s.slot == frame_len - 4'h1);
  // First stage counts an even number of frames, so the interval stays even.
  assign s1_max = {I_FIRST_STAGE_COUNT, 1'b1}; // see R21
  assign s2_max = (I_SECOND_STAGE_COUNT == 6'h0) ? 6'h0 : I_SECOND_STAGE_COUNT - 6'h1; // see R23
  assign last_of_interval = (s.s1 == s1_max) && (s.s2 == s2_max);
  assign penult_of_interval = (s.s1 == s1_max - 3'h1) && (s.s2 == s2_max);
  assign forced_alt = (I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FORCED) && last_of_interval; // see R16, R18
  assign toggle_mode = (I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FORCED) ||
                       (I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FREE);
  assign fifo_pop = fifo_out_valid && (!s.out_valid || I_RAM_WR_READY);
  assign res_mask = (25'h1 << s.res) - 25'h1;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    n = s;
    do_start = 1'b0;
    new_frame = 1'b0;
    start_slot = 4'h0;
    start_alt = s.alt;
    safe_slot = 4'h0;
    n.start = 1'b0;
    n.ck_d = I_SLOW_32K_CLOCK;
    n.req_d = I_ALTERNATE_FRAME_REQUEST;
    n.batt = I_BATTERY_MEASURE_ENABLE; // see R02
    case (I_FILTER_LENGTH_FIELD) // see R09, R10
      2'h0: begin
        n.cycles = CONV_CYCLES_LEN0;
        n.res = ({I_FAST_CLOCK_SEL_HI, I_FAST_CLOCK_SEL_LO} == CLK_SEL_HI_RES) ? RES_HI_LEN0 : RES_STD_LEN0;
      end
      2'h1: begin
        n.cycles = CONV_CYCLES_LEN1;
        n.res = ({I_FAST_CLOCK_SEL_HI, I_FAST_CLOCK_SEL_LO} == CLK_SEL_HI_RES) ? RES_HI_LEN1 : RES_STD_LEN1;
      end
      default: begin
        n.cycles = CONV_CYCLES_LEN2;
        n.res = ({I_FAST_CLOCK_SEL_HI, I_FAST_CLOCK_SEL_LO} == CLK_SEL_HI_RES) ? RES_HI_LEN2 : RES_STD_LEN2;
      end
    endcase
    case (s.state)
      ST_WAIT_EDGE: begin
        if (ck_rise) begin
          do_start = 1'b1;
          new_frame = 1'b1;
        end
      end
      ST_CONVERT: begin
        if (I_CONVERSION_COMPLETE) begin
          n.push_word = {{(ADDR_W-SEL_W){1'b0}}, s.sel,
                         (I_FILTER_DATA & res_mask[FILT_W-1:0]), {RESULT_SHIFT{1'b0}}}; // see R11, R12
          n.state = ST_PUSH;
        end
      end
      ST_PUSH: begin
        if (fifo_in_ready) begin
          n.state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (ck_rise) begin // see R08
          if (last_slot) begin
            n.state = ST_SYNC; // see R13
            n.frame_sync = 1'b1; // see R14
            if (toggle_mode && !(I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FORCED && penult_of_interval)) begin
              n.pol = !s.pol; // see R16, R17, R18
            end
            // A count left above a lowered limit restarts at once instead of wrapping.
            if (s.s1 >= s1_max) begin
              n.s1 = 3'h0;
              n.s2 = (s.s2 >= s2_max) ? 6'h0 : s.s2 + 6'h1;
            end else begin
              n.s1 = s.s1 + 3'h1;
            end
          end else begin
            do_start = 1'b1;
            start_slot = s.slot + 4'h1; // see R06
          end
        end
      end
      ST_SYNC: begin
        if (ck_rise) begin
          n.frame_sync = 1'b0;
          do_start = 1'b1;
          new_frame = 1'b1;
        end
      end
      default: begin
        n.state = ST_WAIT_EDGE;
      end
    endcase
    if (do_start) begin
      if (new_frame) begin
        start_alt = s.pend || forced_alt; // see R03
        n.pend = 1'b0;
      end
      safe_slot = (start_slot < FRAME_LEN_MAX) ? start_slot : 4'h0;
      n.alt = start_alt;
      n.slot = safe_slot; // see R06
      n.sel = start_alt ? alt_sel[safe_slot] : norm_sel[safe_slot]; // see R01
      n.start = 1'b1; // see R07
      n.state = ST_CONVERT;
    end
    // A new request wins over the clear at the frame boundary.
    if (req_rise) begin
      n.pend = 1'b1; // see R04, R24
    end
    if (I_CHOPPER_MODE_FIELD == CHOP_FIXED_LOW) begin
      n.pol = 1'b0; // see R15
    end else if (I_CHOPPER_MODE_FIELD == CHOP_FIXED_HIGH) begin
      n.pol = 1'b1; // see R15
    end
    n.chopper_clock = n.pol;
    if (fifo_pop) begin
      n.out_valid = 1'b1;
      n.out_word = fifo_out_data;
    end else if (I_RAM_WR_READY) begin
      n.out_valid = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------------------
  // Result buffer
  // ---------------------------------------------------------------------------
  amxs_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_SYS_CLK),
    .i_rst(I_SYS_RST),
    .i_in_valid(s.state == ST_PUSH),
    .i_in_data(s.push_word),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(!s.out_valid || I_RAM_WR_READY)
  );

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign O_CONVERSION_START_CMD = s.start;
  assign O_INPUT_SELECT = s.sel;
  assign O_CONV_SLOW_32K_CLOCK_CYCLES = s.cycles;
  assign O_RESOLUTION_BITS = s.res;
  assign O_BATTERY_LOAD_EN = s.batt;
  assign O_CHOPPER_POLARITY = s.pol; // see R19
  assign O_CHOPPER_CLOCK = s.chopper_clock;
  assign O_FRAME_SYNC = s.frame_sync;
  assign O_ALT_FRAME_ACTIVE = s.alt;
  assign O_RAM_WR_VALID = s.out_valid;
  assign O_RAM_WR_ADDR = s.out_word[FIFO_W-1:WORD_W];
  assign O_RAM_WR_DATA = s.out_word[WORD_W-1:0];

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_SYS_RST);

  sequence conv_done_seq;
    s.state == ST_CONVERT && I_CONVERSION_COMPLETE;
  endsequence

  sequence sync_leave_seq;
    s.state == ST_SYNC && ck_rise;
  endsequence

  sequence free_leave_seq;
    sync_leave_seq ##0 (!s.pend && I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FREE);
  endsequence

  chk_start_on_edge: assert property (s.start |-> $past(ck_rise)) // see R07
    else $error("Conversion start without a slow clock edge.");
  chk_wait_after_done: assert property (conv_done_seq |=> !s.start [*2]) // see R08
    else $error("Next slot started without waiting for a slow clock edge.");
  chk_request_caught: assert property (req_rise |=> s.pend || s.alt) // see R04
    else $error("Alternate frame request was lost.");
  chk_pending_served: assert property ((s.state == ST_SYNC && ck_rise && s.pend) |=> s.alt && s.start) // see R03
    else $error("Pending request did not yield an alternate frame.");
  chk_frame_slot0: assert property (sync_leave_seq |=> s.start && s.slot == 4'h0 && !s.frame_sync) // see R06
    else $error("New frame did not start at slot zero.");
  chk_slot_bound: assert property (s.start |-> s.slot < frame_len) // see R05
    else $error("Slot index beyond frame length.");
  chk_sync_one_slow: assert property ($rose(s.frame_sync) |-> $past(s.state == ST_HOLD && last_slot)) // see R14
    else $error("Frame sync raised outside the extra cycle.");
  chk_fixed_low: assert property ((I_CHOPPER_MODE_FIELD == CHOP_FIXED_LOW) [*2] |-> !s.pol && !s.chopper_clock) // see R15
    else $error("Fixed-low chopper mode not held low.");
  chk_free_toggle: assert property (($rose(s.frame_sync) && $past(I_CHOPPER_MODE_FIELD) == CHOP_TOGGLE_FREE)
    |-> s.pol != $past(s.pol)) // see R18
    else $error("Polarity did not toggle at frame end.");
  chk_skip_toggle: assert property ((s.state == ST_HOLD && ck_rise && last_slot && penult_of_interval
    && I_CHOPPER_MODE_FIELD == CHOP_TOGGLE_FORCED) |=> $stable(s.pol)) // see R17
    else $error("Polarity toggled before the forced alternate frame.");
  chk_shift_zero: assert property ((s.state == ST_PUSH) |-> s.push_word[RESULT_SHIFT-1:0] == 8'h00) // see R12
    else $error("Stored result not shifted left by eight.");
  chk_fixed_high: assert property ((I_CHOPPER_MODE_FIELD == CHOP_FIXED_HIGH) [*2] |-> s.pol && s.chopper_clock) // see R15
    else $error("Fixed-high chopper mode not held high.");
  chk_sync_held: assert property ((s.frame_sync && !ck_rise) |=> s.frame_sync) // see R14
    else $error("Frame sync dropped before the next slow clock edge.");
  chk_forced_alt: assert property ((sync_leave_seq ##0 forced_alt) |=> s.alt && s.start) // see R16
    else $error("Forced alternate frame missing at interval end.");
  chk_free_no_force: assert property (free_leave_seq |=> !s.alt) // see R18
    else $error("Alternate frame forced in free toggle mode.");

endmodule

// [verification/amxs_filter_model.sv]
// Purpose: Behavioural decimation filter facing the sequencer's conversion handshake.
// Assumes: One start pulse per conversion; slow clock period given in system cycles.
// Notes: Data changes every cycle outside the completion pulse.

`timescale 1ns/100ps

module amxs_filter_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [1:0] i_cycles,
  input wire logic [31:0] i_rand,
  input wire logic [7:0] i_slow_period,
  output logic o_done,
  output logic [23:0] o_data
);
  int cnt = 0;

  initial begin
    o_done = 1'b0;
    o_data = 24'h0;
  end

  // A conversion lasts the programmed number of slow cycles less 3 to 6 system cycles.
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    o_data <= ~o_data;
    if (i_start) begin
      cnt <= int'(i_cycles) * int'(i_slow_period) - 6 + int'(i_rand[1:0]);
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_done <= 1'b1;
      o_data <= i_rand[23:0];
    end
  end
endmodule

// [verification/amxs_sequencer_bench.sv]
// Purpose: Self-checking bench for the mux sequencer.
// Assumes: The slow clock is shortened to a 40-cycle period.
// Notes: Results are noted in a queue and compared when the RAM port accepts them.

`timescale 1ns/100ps

module amxs_sequencer_bench;
  import amxs_pkg::*;
  localparam int HALF = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic slow_q = 1'b0;
  logic slow_en = 1'b0;
  logic stall = 1'b0;
  logic chk11 = 1'b0;
  logic chk00 = 1'b0;
  logic [39:0] nsel = 40'h120BA93210;
  logic [39:0] asel = 40'hAB39203B1A;
  logic [3:0] flen = 4'h3;
  logic [1:0] flt = 2'h0;
  logic shi = 1'b0;
  logic slo = 1'b0;
  logic [1:0] chop = 2'h3;
  logic req = 1'b0;
  logic battery_measure_enable = 1'b0;
  logic [1:0] fs = 2'h1;
  logic [5:0] ss = 6'h2;
  logic rdy = 1'b0;
  logic done;
  logic [23:0] fdata;
  logic start, bload, pol, chclk, sync, alt, wv;
  logic [3:0] isel;
  logic [1:0] cyc;
  logic [4:0] res;
  logic [9:0] waddr;
  logic [31:0] wdata;
  logic [31:0] lf = 32'hE748786F;
  logic [41:0] wq[$];
  int bad_count = 0;
  int total_checks = 0;
  int ticks = 0;
  int since = 0;
  int scnt = 0;
  logic [3:0] lens[5] = '{4'h1, 4'hA, 4'h0, 4'hD, 4'h4};

  amxs_sequencer amxs_sequencer_i (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_SLOW_32K_CLOCK(slow),
    .I_NORMAL_SLOT_SELECT(nsel), .I_ALTERNATE_SLOT_SELECT(asel), .I_FRAME_LENGTH(flen),
    .I_FILTER_LENGTH_FIELD(flt), .I_FAST_CLOCK_SEL_HI(shi), .I_FAST_CLOCK_SEL_LO(slo),
    .I_CHOPPER_MODE_FIELD(chop), .I_ALTERNATE_FRAME_REQUEST(req), .I_BATTERY_MEASURE_ENABLE(battery_measure_enable),
    .I_FIRST_STAGE_COUNT(fs), .I_SECOND_STAGE_COUNT(ss), .I_CONVERSION_COMPLETE(done),
    .I_FILTER_DATA(fdata), .I_RAM_WR_READY(rdy), .O_CONVERSION_START_CMD(start), .O_INPUT_SELECT(isel),
    .O_CONV_SLOW_32K_CLOCK_CYCLES(cyc), .O_RESOLUTION_BITS(res), .O_BATTERY_LOAD_EN(bload),
    .O_CHOPPER_POLARITY(pol), .O_CHOPPER_CLOCK(chclk), .O_FRAME_SYNC(sync), .O_ALT_FRAME_ACTIVE(alt),
    .O_RAM_WR_VALID(wv), .O_RAM_WR_ADDR(waddr), .O_RAM_WR_DATA(wdata));

  amxs_filter_model amxs_filter_model_i (.i_clk(clk), .i_start(start), .i_cycles(cyc), .i_rand(lf),
    .i_slow_period(8'(2 * HALF)), .o_done(done), .o_data(fdata));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [4:0] exp_res(input logic h, input logic [1:0] l);
    if (l == 2'h0) return h ? 5'h13 : 5'h12;
    if (l == 2'h1) return h ? 5'h16 : 5'h15;
    return h ? 5'h18 : 5'h16;
  endfunction

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [41:0] got, input logic [41:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wait_sync(input int n);
    repeat (n) @(posedge sync);
    @(posedge clk);
  endtask

  task automatic pulse_req;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
  endtask

  initial begin
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    lf <= lfsr(lf);
    rdy <= stall ? 1'b0 : (lf[1:0] != 2'h0);
    ticks <= ticks + 1;
    if (slow_en) begin
      scnt <= (scnt == HALF - 1) ? 0 : scnt + 1;
      if (scnt == HALF - 1) slow <= ~slow;
    end
    slow_q <= slow;
    since <= (slow && !slow_q) ? 0 : since + 1;
    // The ceiling is several times the length of the whole sequence.
    if (ticks == 40000) begin
      bad_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------------------
  // Output watcher
  // ---------------------------------------------------------------------------
  logic [3:0] slot = 4'h0;
  logic [3:0] cur = 4'h0;
  logic [3:0] exp_len = 4'h0;
  logic exp_alt = 1'b0;
  logic pend = 1'b0;
  logic req_d = 1'b0;
  logic sync_d = 1'b0;
  logic pol_d = 1'b0;
  int nstart = 0;

  always @(posedge clk) begin
    if (!rst) begin
      if (req && !req_d) pend = 1'b1;
      if (start) begin
        if (slot == 4'h0) begin
          exp_len = (flen == 4'h0) ? 4'h1 : (flen > 4'hA) ? 4'hA : flen;
          exp_alt = chk00 ? !exp_alt : chk11 ? pend : alt;
          pend = 1'b0;
        end
        if (chk00 || chk11) chk_val(8'(alt), 8'(exp_alt));
        cur = 4'((exp_alt ? asel : nsel) >> (slot * 4));
        chk_val(8'(isel), 8'(cur));
        chk_val(8'(since < 4), 8'h1);
        slot++;
        nstart++;
      end
      if (done) wq.push_back({6'h0, cur, fdata & (24'hFFFFFF >> (24 - exp_res(!shi && slo, flt))), 8'h00});
      if (sync && !sync_d) begin
        chk_val(8'(nstart), 8'(exp_len));
        if (chk11) chk_val(8'({pol, chclk}), 8'({!pol_d, !pol_d}));
        if (chk00) chk_val(8'(pol), 8'(pol_d ^ exp_alt));
        slot = 4'h0;
        nstart = 0;
      end
      if (wv && rdy) chk_word({waddr, wdata}, (wq.size() > 0) ? wq.pop_front() : '1);
    end
    req_d = req;
    sync_d = sync;
    pol_d = pol;
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      {shi, slo} <= 2'(i / 3);
      flt <= 2'(i % 3);
      battery_measure_enable <= i[0];
      chop <= i[0] ? 2'h1 : 2'h2;
      repeat (3) @(posedge clk);
      chk_val(8'(res), 8'(exp_res(!shi && slo, flt)));
      chk_val(8'(cyc), 8'(flt + 2'h1));
      chk_val(8'(bload), 8'(battery_measure_enable));
      chk_val(8'({pol, chclk}), battery_measure_enable ? 8'h0 : 8'h3);
    end
    {shi, slo} <= 2'h1;
    flt <= 2'h0;
    chop <= 2'h3;
    slow_en <= 1'b1;
    wait_sync(2);
    chk11 <= 1'b1;
    foreach (lens[k]) begin
      flen <= lens[k];
      wait_sync(2);
    end
    @(posedge start);
    repeat (5) @(posedge clk);
    pulse_req();
    wait_sync(1);
    @(posedge start);
    repeat (60) @(posedge clk);
    pulse_req();
    wait_sync(3);
    flen <= 4'hA;
    wait_sync(1);
    stall <= 1'b1;
    repeat (900) @(posedge clk);
    stall <= 1'b0;
    wait_sync(2);
    chk11 <= 1'b0;
    chop <= 2'h0;
    flen <= 4'h2;
    flt <= 2'h2;
    shi <= 1'b1;
    fs <= 2'h0;
    ss <= 6'h1;
    wait_sync(3);
    chk00 <= 1'b1;
    wait_sync(4);
    end_sim();
  end
endmodule
